// *** logic/epm_map.vh ***
`ifndef EPM_MAP_VH
`define EPM_MAP_VH
// ****************************************************************
// command opcodes
// ****************************************************************
`define EPM_OP_STANDBY      8'he0
`define EPM_OP_SLEEP        8'he1
`define EPM_OP_POWER_DOWN   8'he2
`define EPM_OP_AUX_VWRITE   8'he5
`define EPM_OP_AUX_PWRITE   8'he6
`define EPM_OP_AUX_PREPARE  8'he7
`define EPM_OP_RESP_READ    8'hf9
`define EPM_OP_STATUS_READ  8'h05
`define EPM_OP_WRITE_LATCH  8'h06
// ****************************************************************
// status word fields
// ****************************************************************
`define EPM_ST_READY_N_BIT  0
`define EPM_ST_WEL_BIT      1
`define EPM_ST_SECT_LSB     8
// ****************************************************************
// reset values
// ****************************************************************
`define EPM_AUX_CFG_RST     32'h0000_0000
`define EPM_SECT_EN_RST     8'hff
// ****************************************************************
// timing, ns and derived cycles at 8 ns
// ****************************************************************
`define EPM_CLK_NS          8
`define EPM_CS_WAKE_ARM_NS  1000000
`define EPM_CS_WAKE_ARM_CYC ((`EPM_CS_WAKE_ARM_NS + `EPM_CLK_NS - 1) / `EPM_CLK_NS)
`define EPM_PD_WAKE_CYC     2000
`define EPM_SLEEP_WAKE_CYC  200
`define EPM_SHUTDOWN_CYC    200
`endif

// *** logic/epm_sync.v ***
`timescale 1ns/1ps
// ****************************************************************
// three-stage pin synchroniser; a change counts once stages 2 and 3 agree
// ****************************************************************
module epm_sync #(
  parameter RST_VAL = 1'b0
) (
  input  wire clock,
  input  wire sys_rst,
  input  wire pin_in,
  output reg  level_out,
  output wire rise_pulse,
  output wire fall_pulse
);
  reg  s1_reg;   // metastability catch, read by s2 only
  reg  s2_reg;
  reg  s3_reg;

  // shift chain plus settled level
  always @(posedge clock) begin
    if (sys_rst) begin
      s1_reg    <= RST_VAL;
      s2_reg    <= RST_VAL;
      s3_reg    <= RST_VAL;
      level_out <= RST_VAL;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // agreement of 2 and 3 updates the settled level
      if (s2_reg == s3_reg) begin
        level_out <= s3_reg;
      end
    end
  end

  assign rise_pulse = (s2_reg == s3_reg) &&  s3_reg && !level_out;
  assign fall_pulse = (s2_reg == s3_reg) && !s3_reg &&  level_out;
endmodule // epm_sync

// *** logic/epm_ctrl.v ***
`timescale 1ns/1ps
`include "epm_map.vh"
module epm_ctrl #(
  parameter CS_ARM_CYC   = `EPM_CS_WAKE_ARM_CYC,
  parameter PD_WAKE_CYC  = `EPM_PD_WAKE_CYC,
  parameter SLP_WAKE_CYC = `EPM_SLEEP_WAKE_CYC,
  parameter SHDN_CYC     = `EPM_SHUTDOWN_CYC
) (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        spi_cs_n,
  input  wire        spi_sck,
  input  wire        spi_mosi,
  input  wire        wake_pin,
  input  wire        program_busy,
  input  wire [31:0] aux_cfg_stored,
  input  wire [7:0]  sector_enable,
  output reg         spi_miso,
  output reg         spi_miso_oe_n,
  output reg         supply_on,
  output reg         array_on,
  output reg  [7:0]  sector_power,
  output reg         aux_supply_on,
  output reg  [31:0] aux_cfg,
  output reg         aux_store_req,
  output reg  [31:0] aux_store_data,
  output reg         ready_n,
  output reg  [2:0]  mode
);
  // ****************************************************************
  // modes
  // ****************************************************************
  localparam M_PDOWN    = 3'h0;  // all supplies off until a chip-select wake begins
  localparam M_PD_WAKE  = 3'h1;  // ramping out of power-down
  localparam M_STANDBY  = 3'h2;  // array powered, ready
  localparam M_SLEEP    = 3'h3;  // array off, supplies kept
  localparam M_SL_WAKE  = 3'h4;  // switching sectors on
  localparam M_SHUTDOWN = 3'h5;  // shutdown sequence running
  localparam M_BOOT     = 3'h6;  // start-up; wake low goes to power-down, else waits for chip-select high
  // timer loads cut to the timer's width on purpose
  localparam [20:0] PD_WAKE_T  = PD_WAKE_CYC[20:0];
  localparam [20:0] SLP_WAKE_T = SLP_WAKE_CYC[20:0];
  localparam [20:0] SHDN_T     = SHDN_CYC[20:0];

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  wire cs_lvl;
  wire cs_rise;
  wire cs_fall;
  wire sck_rise;
  wire sck_fall;
  wire wake_lvl;
  wire wake_rise;
  wire mosi_lvl;

  epm_sync #(.RST_VAL(1'b1)) u_cs (
    .clock(clock), .sys_rst(sys_rst), .pin_in(spi_cs_n),
    .level_out(cs_lvl), .rise_pulse(cs_rise), .fall_pulse(cs_fall));
  epm_sync #(.RST_VAL(1'b0)) u_sck (
    .clock(clock), .sys_rst(sys_rst), .pin_in(spi_sck),
    .level_out(), .rise_pulse(sck_rise), .fall_pulse(sck_fall));
  epm_sync #(.RST_VAL(1'b0)) u_wake (
    .clock(clock), .sys_rst(sys_rst), .pin_in(wake_pin),
    .level_out(wake_lvl), .rise_pulse(wake_rise), .fall_pulse());
  epm_sync #(.RST_VAL(1'b0)) u_mosi (
    .clock(clock), .sys_rst(sys_rst), .pin_in(spi_mosi),
    .level_out(mosi_lvl), .rise_pulse(), .fall_pulse());

  // ****************************************************************
  // state
  // ****************************************************************
  reg  [2:0]  mode_reg;          // current power mode
  reg  [20:0] tmr_reg;           // wake and shutdown timer
  reg  [20:0] arm_reg;           // boot arming counter
  reg         cs_armed_reg;      // chip-select wake allowed
  reg         wake_seen_reg;     // strap sample taken
  reg         cs_was_low_reg;    // chip-select went low in power-down
  reg  [7:0]  shift_reg;         // incoming bits
  reg  [2:0]  bit_cnt_reg;       // bit within byte
  reg  [2:0]  byte_cnt_reg;      // byte within frame
  reg  [7:0]  opcode_reg;        // first byte of frame
  reg  [31:0] cfg_buf_reg;       // data bytes collected
  reg         wel_reg;           // write latch
  reg  [31:0] resp_reg;          // prepared response word
  reg  [31:0] tx_reg;            // outgoing shift word

  wire        frame_act = !cs_lvl && (mode_reg == M_STANDBY || mode_reg == M_SLEEP);
  wire        byte_done = frame_act && sck_rise && (bit_cnt_reg == 3'd7);
  wire [7:0]  rx_byte   = {shift_reg[6:0], mosi_lvl};
  wire        in_sleep  = (mode_reg == M_SLEEP);
  wire [31:0] status_w  = {16'h0000, sector_power, 6'h00, wel_reg, ready_n};

  // ****************************************************************
  // power mode sequencer and command decoder
  // ****************************************************************
  always @(posedge clock) begin
    if (sys_rst) begin
      mode_reg       <= M_BOOT;
      tmr_reg        <= 21'h000000;
      arm_reg        <= 21'h000000;
      cs_armed_reg   <= 1'b0;
      wake_seen_reg  <= 1'b0;
      cs_was_low_reg <= 1'b0;
      shift_reg      <= 8'h00;
      bit_cnt_reg    <= 3'h0;
      byte_cnt_reg   <= 3'h0;
      opcode_reg     <= 8'h00;
      cfg_buf_reg    <= 32'h0000_0000;
      wel_reg        <= 1'b0;
      resp_reg       <= 32'h0000_0000;
      tx_reg         <= 32'h0000_0000;
      aux_cfg        <= `EPM_AUX_CFG_RST;
      aux_store_req  <= 1'b0;
      aux_store_data <= 32'h0000_0000;
    end else begin
      aux_store_req <= 1'b0;
      if (!cs_armed_reg) begin
        arm_reg <= arm_reg + 21'h000001;
        if (arm_reg >= CS_ARM_CYC - 1) begin
          cs_armed_reg <= 1'b1;
        end
      end
      if (tmr_reg != 21'h000000) begin
        tmr_reg <= tmr_reg - 21'h000001;
      end
      case (mode_reg)
        M_BOOT: begin
          aux_cfg <= aux_stored_safe(aux_cfg_stored);
          // strap sample, a few cycles after release once sync settles
          if (arm_reg == 21'h000004) begin
            wake_seen_reg <= 1'b1;
            // wake low at start keeps power-down
            if (!wake_lvl) begin
              mode_reg <= M_PDOWN;
            end else if (cs_lvl) begin
              mode_reg <= M_PD_WAKE;
              tmr_reg  <= PD_WAKE_T;
            end
          end else if (wake_seen_reg && cs_lvl) begin
            mode_reg <= M_PD_WAKE;
            tmr_reg  <= PD_WAKE_T;
          end
        end
        M_PDOWN: begin
          if (cs_fall && cs_armed_reg) begin
            cs_was_low_reg <= 1'b1;
          end
          // ready time counts from chip-select release
          if (cs_rise && cs_was_low_reg) begin
            cs_was_low_reg <= 1'b0;
            mode_reg       <= M_PD_WAKE;
            tmr_reg        <= PD_WAKE_T;
          end else if (wake_rise) begin
            // a half-done chip-select wake must not hold supplies up later
            cs_was_low_reg <= 1'b0;
            mode_reg       <= M_PD_WAKE;
            tmr_reg        <= PD_WAKE_T;
          end
        end
        M_PD_WAKE: begin
          if (tmr_reg == 21'h000000 && cs_lvl) begin
            mode_reg <= M_STANDBY;
          end
        end
        M_SL_WAKE: begin
          // sectors on after sleep wake time
          if (tmr_reg == 21'h000000) begin
            mode_reg <= M_STANDBY;
          end
        end
        M_SHUTDOWN: begin
          if (tmr_reg == 21'h000000) begin
            mode_reg <= M_PDOWN;
          end
        end
        default: begin
          // standby or sleep: serial frame handling
          if (cs_fall) begin
            bit_cnt_reg  <= 3'h0;
            byte_cnt_reg <= 3'h0;
          end
          if (frame_act && sck_rise) begin
            shift_reg   <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
          end
          // the fall right after the opcode keeps the first bit up for the next rise
          if (frame_act && sck_fall && !(byte_cnt_reg == 3'h1 && bit_cnt_reg == 3'h0)) begin
            tx_reg <= {tx_reg[30:0], 1'b0};
          end
          if (byte_done) begin
            if (byte_cnt_reg != 3'h7) begin
              byte_cnt_reg <= byte_cnt_reg + 3'h1;
            end
            if (byte_cnt_reg == 3'h0) begin
              opcode_reg <= rx_byte;
              if (rx_byte == `EPM_OP_STATUS_READ) begin
                tx_reg <= status_w;
              end else if (rx_byte == `EPM_OP_RESP_READ && !in_sleep) begin
                tx_reg <= resp_reg;
              end
            end else if (byte_cnt_reg <= 3'h4) begin
              cfg_buf_reg <= {cfg_buf_reg[23:0], rx_byte};
            end
          end
          // commands act at chip-select release
          if (cs_rise) begin
            // counters cleared so a frame begun elsewhere cannot replay this command
            bit_cnt_reg  <= 3'h0;
            byte_cnt_reg <= 3'h0;
            if (byte_cnt_reg == 3'h1) begin
              if (!in_sleep || opcode_reg == `EPM_OP_STANDBY || opcode_reg == `EPM_OP_POWER_DOWN) begin
                case (opcode_reg)
                  `EPM_OP_POWER_DOWN: begin
                    if (!program_busy) begin
                      mode_reg <= M_SHUTDOWN;
                      tmr_reg  <= SHDN_T;
                    end
                  end
                  `EPM_OP_SLEEP: begin
                    if (!program_busy) begin
                      mode_reg <= M_SLEEP;
                    end
                  end
                  `EPM_OP_STANDBY: begin
                    if (in_sleep) begin
                      mode_reg <= M_SL_WAKE;
                      tmr_reg  <= SLP_WAKE_T;
                    end
                  end
                  `EPM_OP_WRITE_LATCH: begin
                    wel_reg <= 1'b1;
                  end
                  `EPM_OP_AUX_PREPARE: begin
                    resp_reg <= aux_cfg;
                  end
                  default: begin
                  end
                endcase
              end
            end else if (byte_cnt_reg == 3'h5 && !in_sleep) begin
              if (opcode_reg == `EPM_OP_AUX_VWRITE) begin
                aux_cfg <= cfg_buf_reg;
              end else if (opcode_reg == `EPM_OP_AUX_PWRITE && wel_reg) begin
                aux_cfg        <= cfg_buf_reg;
                aux_store_req  <= 1'b1;
                aux_store_data <= cfg_buf_reg;
                wel_reg        <= 1'b0;
              end
            end
          end
        end
      endcase
    end
  end

  // stored image passes straight through; kept as a hook for screening
  function [31:0] aux_stored_safe;
    input [31:0] v;
    begin
      aux_stored_safe = v;
    end
  endfunction

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  always @(posedge clock) begin
    if (sys_rst) begin
      supply_on     <= 1'b0;
      array_on      <= 1'b0;
      sector_power  <= 8'h00;
      aux_supply_on <= 1'b0;
      ready_n       <= 1'b1;
      mode          <= M_BOOT;
      spi_miso      <= 1'b0;
      spi_miso_oe_n <= 1'b1;
    end else begin
      mode <= mode_reg;
      // supplies rise once chip-select wake begins
      supply_on <= (mode_reg != M_PDOWN && mode_reg != M_BOOT) || cs_was_low_reg;
      // array off in sleep, supplies kept
      array_on <= (mode_reg == M_STANDBY);
      sector_power <= (mode_reg == M_STANDBY) ? sector_enable : 8'h00;
      aux_supply_on <= (mode_reg == M_STANDBY) && aux_cfg[16];
      ready_n <= !((mode_reg == M_STANDBY || mode_reg == M_SLEEP) && !program_busy);
      spi_miso      <= tx_reg[31];
      spi_miso_oe_n <= !(frame_act && byte_cnt_reg != 3'h0);
    end
  end
endmodule // epm_ctrl

// *** tb/epm_ctrl_checker.sv ***
`timescale 1ns/1ps
// ****************************************
// port-level checker for the power-mode controller
// ****************************************
module epm_ctrl_checker #(
  parameter CS_ARM_CYC   = 50,
  parameter PD_WAKE_CYC  = 20,
  parameter SLP_WAKE_CYC = 10,
  parameter SHDN_CYC     = 10
) (
  input wire       clock,
  input wire       sys_rst,
  input wire       spi_cs_n,
  input wire       program_busy,
  input wire [7:0] sector_enable,
  input wire       spi_miso_oe_n,
  input wire       supply_on,
  input wire       array_on,
  input wire [7:0] sector_power,
  input wire       aux_supply_on,
  input wire       aux_store_req,
  input wire       ready_n,
  input wire [2:0] mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  reg [2:0]  prev_mode_reg; // mode one cycle back
  reg [31:0] run_cnt_reg;   // cycles the previous mode has lasted
  reg [31:0] arm_cnt_reg;   // cycles since reset, saturating past the arm time
  // run length of each mode; a change reports the old run's length
  always @(posedge clock) begin
    if (sys_rst) begin
      prev_mode_reg <= 3'h6;
      run_cnt_reg   <= 32'h0;
      arm_cnt_reg   <= 32'h0;
    end else begin
      prev_mode_reg <= mode;
      run_cnt_reg   <= (mode != prev_mode_reg) ? 32'h1 : run_cnt_reg + 32'h1;
      if (arm_cnt_reg < CS_ARM_CYC + 8) arm_cnt_reg <= arm_cnt_reg + 32'h1;
    end
  end
  chk_sleep_rails: assert property (mode == 3'h3 |-> !array_on && !aux_supply_on && supply_on)
    else $error("sleep rails wrong");
  chk_standby_sectors: assert property ((mode == 3'h2 && prev_mode_reg == 3'h2) |->
    array_on && sector_power == sector_enable)
    else $error("standby sectors wrong");
  chk_ready_modes: assert property (!ready_n |-> (mode == 3'h2 || mode == 3'h3))
    else $error("ready outside active modes");
  chk_wake_not_ready: assert property ((mode == 3'h1 || mode == 3'h4) && prev_mode_reg == mode |-> ready_n)
    else $error("ready during wake");
  chk_sleep_wake_len: assert property ((prev_mode_reg == 3'h4 && mode != 3'h4) |->
    mode == 3'h2 && run_cnt_reg >= SLP_WAKE_CYC - 1 && run_cnt_reg <= SLP_WAKE_CYC + 1)
    else $error("sleep wake length wrong");
  chk_pd_wake_len: assert property ((prev_mode_reg == 3'h1 && mode != 3'h1) |->
    mode == 3'h2 && run_cnt_reg >= PD_WAKE_CYC - 1)
    else $error("power-down wake too short");
  chk_cs_ramp: assert property ((mode == 3'h0 && $past(mode) == 3'h0 && $fell(spi_cs_n) && arm_cnt_reg > CS_ARM_CYC)
    |-> ##[1:8] supply_on)
    else $error("no ramp on chip-select");
  chk_busy_hold: assert property ((program_busy && $past(program_busy) && $past(mode) == 3'h2) |->
    mode == 3'h2 && ready_n)
    else $error("mode left while busy");
  chk_store_pulse: assert property (aux_store_req |=> !aux_store_req)
    else $error("store pulse too long");
  chk_shutdown_exit: assert property ((prev_mode_reg == 3'h5 && mode != 3'h5) |-> mode == 3'h0)
    else $error("shutdown did not end in power-down");
  chk_miso_release: assert property ((spi_cs_n && $past(spi_cs_n, 5)) |-> spi_miso_oe_n)
    else $error("miso driven outside frame");
endmodule // epm_ctrl_checker

bind epm_ctrl epm_ctrl_checker #(.CS_ARM_CYC(CS_ARM_CYC), .PD_WAKE_CYC(PD_WAKE_CYC),
  .SLP_WAKE_CYC(SLP_WAKE_CYC), .SHDN_CYC(SHDN_CYC)) u_epm_ctrl_checker (
  .clock(clock), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n), .program_busy(program_busy),
  .sector_enable(sector_enable), .spi_miso_oe_n(spi_miso_oe_n), .supply_on(supply_on),
  .array_on(array_on), .sector_power(sector_power), .aux_supply_on(aux_supply_on),
  .aux_store_req(aux_store_req), .ready_n(ready_n), .mode(mode));

// *** tb/epm_spi_host.sv ***
`timescale 1ns/1ps
// ****************************************
// host model: chip-select, serial clock, data and wake pin
// ****************************************
module epm_spi_host (
  input  wire clock,
  input  wire miso,
  output reg  cs_n,
  output reg  sck,
  output reg  mosi,
  output reg  wake
);
  // idle: deselected, clock parked low between frames
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    mosi = 1'b0;
    wake = 1'b0;
  end
  // one frame, msb first; sck half period 8 clocks, close to 125 ns period
  // frame format
  task frame(input [39:0] tx, input integer nbits, output [31:0] rx);
    integer i;
    begin
      rx = 32'h0;
      @(posedge clock);
      cs_n <= 1'b0;
      repeat (8) @(posedge clock);
      for (i = 0; i < nbits; i = i + 1) begin
        mosi <= tx[39-i];
        repeat (8) @(posedge clock);
        sck <= 1'b1;
        repeat (7) @(posedge clock);
        if (i >= 8) rx = {rx[30:0], miso};
        @(posedge clock);
        sck <= 1'b0;
      end
      repeat (8) @(posedge clock);
      cs_n <= 1'b1;
      // released data line shows the inverse, not a stale bit
      mosi <= ~mosi;
      repeat (8) @(posedge clock);
    end
  endtask
  task pulse_cs;
    begin
      @(posedge clock);
      cs_n <= 1'b0;
      repeat (30) @(posedge clock);
      cs_n <= 1'b1;
      @(posedge clock);
    end
  endtask
  task set_wake(input lvl);
    begin
      @(posedge clock);
      wake <= lvl;
    end
  endtask
endmodule // epm_spi_host

// *** tb/epm_ctrl_tb.sv ***
`timescale 1ns/1ps
`include "epm_map.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module epm_ctrl_tb;
  reg clock = 1'b0;  reg sys_rst = 1'b1;  reg program_busy = 1'b0;
  wire cs_n, sck, mosi, wake, miso, miso_oe_n, supply_on, array_on, aux_supply_on, aux_store_req, ready_n;
  wire [7:0] sector_power;
  wire [31:0] aux_cfg, aux_store_data;
  wire [2:0] mode;
  integer error_cnt = 0;  integer num_checks = 0;  integer store_cnt = 0;
  reg [31:0] rx, store_val;
  reg [31:0] aux_cfg_stored = 32'h0000_0000;  // persisted image, fed back from store pulses
  reg [7:0]  sector_enable  = 8'h5a;          // enabled sectors, changed while asleep
  localparam ARM_CYC = 50, PDW_CYC = 20, SLW_CYC = 10, SHD_CYC = 10;  // shortened times
  always #4 clock = ~clock;
  epm_spi_host u_epm_spi_host (.clock(clock), .miso(miso), .cs_n(cs_n), .sck(sck), .mosi(mosi), .wake(wake));
  epm_ctrl #(.CS_ARM_CYC(ARM_CYC), .PD_WAKE_CYC(PDW_CYC), .SLP_WAKE_CYC(SLW_CYC), .SHDN_CYC(SHD_CYC)) u_epm_ctrl (
    .clock(clock), .sys_rst(sys_rst), .spi_cs_n(cs_n), .spi_sck(sck), .spi_mosi(mosi), .wake_pin(wake),
    .program_busy(program_busy), .aux_cfg_stored(aux_cfg_stored), .sector_enable(sector_enable), .spi_miso(miso),
    .spi_miso_oe_n(miso_oe_n), .supply_on(supply_on), .array_on(array_on), .sector_power(sector_power),
    .aux_supply_on(aux_supply_on), .aux_cfg(aux_cfg), .aux_store_req(aux_store_req),
    .aux_store_data(aux_store_data), .ready_n(ready_n), .mode(mode));
  // count persist pulses and keep the last value handed over
  always @(posedge clock) if (aux_store_req === 1'b1) begin store_cnt++; store_val = aux_store_data; end
  task close_out;
    begin
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task settle(input integer n); repeat (n) @(negedge clock); endtask
  task cmd(input [7:0] op); begin u_epm_spi_host.frame({op, 32'h0}, 8, rx); settle(4); end endtask
  task cmd5(input [7:0] op, input [31:0] d); begin u_epm_spi_host.frame({op, d}, 40, rx); settle(4); end endtask
  // bounded wait for a mode, then compare it
  task wait_mode(input [2:0] m, input integer lim);
    integer i;
    begin
      for (i = 0; i < lim && mode !== m; i = i + 1) @(negedge clock);
      `CHK(mode, m)
    end
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    settle(10);
    `CHK(mode, 3'h0)
    // chip-select before the arm time must not wake
    u_epm_spi_host.pulse_cs();
    settle(20);
    `CHK(mode, 3'h0)
    u_epm_spi_host.set_wake(1'b1);
    wait_mode(3'h2, 200);
    `CHK(ready_n, 1'b0)
    `CHK(sector_power, 8'h5a)
    u_epm_spi_host.set_wake(1'b0);
    cmd5(`EPM_OP_STATUS_READ, 32'h0);
    `CHK(rx[0], 1'b0)
    `CHK(rx[15:8], 8'h5a)
    cmd5(`EPM_OP_AUX_VWRITE, 32'h0001_a5c3);
    `CHK(aux_cfg, 32'h0001_a5c3)
    `CHK(aux_supply_on, 1'b1)
    cmd(`EPM_OP_AUX_PREPARE);
    cmd5(`EPM_OP_RESP_READ, 32'h0);
    `CHK(rx, 32'h0001_a5c3)
    // persistent write without the latch is dropped, with it stored
    cmd5(`EPM_OP_AUX_PWRITE, 32'h1235_5678);
    `CHK(store_cnt, 0)
    cmd(`EPM_OP_WRITE_LATCH);
    cmd5(`EPM_OP_AUX_PWRITE, 32'h1235_5678);
    `CHK(store_cnt, 1)
    `CHK(store_val, 32'h1235_5678)
    `CHK(aux_supply_on, 1'b1)
    @(posedge clock);
    program_busy <= 1'b1;
    cmd(`EPM_OP_SLEEP);
    `CHK(mode, 3'h2)
    cmd(`EPM_OP_POWER_DOWN);
    `CHK(mode, 3'h2)
    `CHK(ready_n, 1'b1)
    @(posedge clock);
    program_busy <= 1'b0;
    cmd(`EPM_OP_SLEEP);
    wait_mode(3'h3, 20);
    `CHK(array_on, 1'b0)
    `CHK(supply_on, 1'b1)
    `CHK(aux_supply_on, 1'b0)
    cmd5(`EPM_OP_STATUS_READ, 32'h0);
    `CHK(rx[0], 1'b0)
    cmd5(`EPM_OP_AUX_VWRITE, 32'h0000_0011);
    `CHK(aux_cfg, 32'h1235_5678)
    `CHK(mode, 3'h3)
    // a new sector set while asleep must be the one switched on
    @(posedge clock);
    sector_enable <= 8'h3c;
    u_epm_spi_host.frame({`EPM_OP_STANDBY, 32'h0}, 8, rx);
    wait_mode(3'h4, 20);
    `CHK(ready_n, 1'b1)
    wait_mode(3'h2, 30);
    `CHK(ready_n, 1'b0)
    `CHK(sector_power, 8'h3c)
    cmd(`EPM_OP_SLEEP);
    wait_mode(3'h3, 20);
    u_epm_spi_host.frame({`EPM_OP_POWER_DOWN, 32'h0}, 8, rx);
    wait_mode(3'h5, 20);
    wait_mode(3'h0, 40);
    `CHK(supply_on, 1'b0)
    u_epm_spi_host.pulse_cs();
    `CHK(supply_on, 1'b1)
    wait_mode(3'h2, 100);
    `CHK(ready_n, 1'b0)
    // a second power-on reloads the persisted configuration
    @(posedge clock);
    aux_cfg_stored <= store_val;
    sys_rst        <= 1'b1;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    settle(10);
    `CHK(aux_cfg, 32'h1235_5678)
    `CHK(mode, 3'h0)
    close_out();
  end
  // watchdog: the sequence needs about 6200 cycles
  initial begin
    repeat (30000) @(posedge clock);
    error_cnt++;
    close_out();
  end
endmodule // epm_ctrl_tb
